// ### hdl/ltw_params.svh
// Purpose: constants for the long table write controller
// Assumes: included by bare name from the design files
// Notes: byte addresses on the register bus, one 32-bit word each
`ifndef LTW_PARAMS_SVH
`define LTW_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define LTW_OFS_CTRL 8'h00
`define LTW_OFS_STAT 8'h04
`define LTW_OFS_DUR 8'h08
`define LTW_OFS_CNT 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LTW_CTRL_CLR 0
`define LTW_ST_BUSY 0
`define LTW_ST_DONE 1
`define LTW_ST_VEC 2
`define LTW_ST_ABORT 3
`define LTW_ST_SHORT 4
`define LTW_ST_VPP 5
`define LTW_ST_PROG 6
`define LTW_ST_CAUSE_LO 8
`define LTW_ST_CAUSE_HI 11

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define LTW_RST_WORD 32'h0000_0000
`define LTW_RST_CNT 16'h0000
`define LTW_SHORT_CYCLES 2'd2

`endif

// ### hdl/ltw_pkg.sv
// Purpose: types shared by the long table write controller
// Assumes: nothing is imported, users write ltw_pkg::name
// Notes: state codes are one-hot
package ltw_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHORT = 3'h2,
    ST_LONG  = 3'h4
  } wstate_t;

  // one bit per source: 0 edge pin, 1 timer overflow, 2 timer clock pin, 3 peripheral
  typedef logic [3:0] srcvec_t;

endpackage

// ### hdl/ltw_src_if.sv
// Purpose: carries interrupt source state to the priority picker
// Assumes: all signals on the core clock
// Notes: ctl side drives flags and enables, arb side answers
interface ltw_src_if;
  logic [2:0] core_flag;
  logic [2:0] core_en;
  logic per_flag;
  logic per_en;
  logic pending;
  ltw_pkg::srcvec_t win;
  logic win_core;

  modport ctl (output core_flag, output core_en, output per_flag, output per_en,
               input pending, input win, input win_core);
  modport arb (input core_flag, input core_en, input per_flag, input per_en,
               output pending, output win, output win_core);
endinterface

// ### hdl/ltw_prio.sv
// Purpose: picks the highest priority enabled and flagged source
// Assumes: priority edge pin > timer overflow > timer clock pin > peripheral
// Notes: purely combinational
module ltw_prio (
  // source state in, winner out
  ltw_src_if.arb src
);

  // ----------------------------------------------------------------
  // qualified sources
  // ----------------------------------------------------------------
  // a source counts only with both its enable and its flag set
  wire [3:0] live = {src.per_flag & src.per_en, src.core_flag & src.core_en};

  // lowest index wins, so isolate the lowest set bit
  wire [3:0] first = live & (~live + 4'h1);

  assign src.pending = |live;
  assign src.win = first;
  assign src.win_core = |first[2:0];

endmodule

// ### hdl/long_table_write_control.sv
// Purpose: long table write sequencer for internal program memory
// Assumes: core, flags and enables on MCLK_I; programming voltage sense is a pin
// Notes: registers on a classic Wishbone slave, one wait state per access
// Behaviour
// [RULE1] internal table write starts long write and halts the core until ended
// [RULE2] only reset or an enabled and flagged interrupt source ends the long write
// [RULE3] global interrupt disable never blocks termination, only the vector branch
// [RULE4] core source ending the write has its highest priority flag cleared
// [RULE5] pending enabled interrupt at issue aborts write as no-op, clears core flag
// [RULE6] peripheral source ending the write keeps its flag set
// [RULE7] after termination vector if global disable clear, else just continue
// [RULE8] core source, disable 0: end write, branch, flag cleared
// [RULE9] core source, disable 1: end write, no branch, flag cleared
// [RULE10] peripheral, disable 1: end, no branch, flag kept; disabled sources do nothing
// [RULE11] no programming voltage: short two-cycle write, memory untouched
// [RULE12] software disables other sources, raises voltage, clears watchdog, writes, verifies
// [RULE13] write ending without vector resumes at next instruction next cycle
//
// The register addresses and the Wishbone register port are this design's own decisions.
`include "ltw_params.svh"

module long_table_write_control (
  // clock, reset, enable
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // instruction sequencer
  input wire logic TBLWT_REQ_I,
  input wire logic TBLWT_INTERNAL_I,
  output logic HALT_O,
  output logic PROG_O,
  output logic ABORT_O,
  output logic VECTOR_O,
  output logic RESUME_O,
  // interrupt logic
  input wire logic [2:0] CORE_FLAG_I,
  input wire logic [2:0] CORE_EN_I,
  input wire logic PER_FLAG_I,
  input wire logic PER_EN_I,
  input wire logic GLOBAL_INTERRUPT_DISABLE_I,
  output logic [2:0] CORE_FLAG_CLR_O,
  // programming voltage sense pin
  input wire logic VPP_PRESENT_I
);

  // ----------------------------------------------------------------
  // source priority
  // ----------------------------------------------------------------
  ltw_src_if src ();

  // flags and enables come from logic on this clock, no synchroniser
  assign src.core_flag = CORE_FLAG_I;
  assign src.core_en = CORE_EN_I;
  assign src.per_flag = PER_FLAG_I;
  assign src.per_en = PER_EN_I;

  ltw_prio u_prio (
    .src(src)
  );

  // [RULE6] peripheral flag kept
  // only a core winner gets its flag cleared, peripherals clear in software
  wire [2:0] core_clr = src.win_core ? src.win[2:0] : 3'h0;
  wire gid = GLOBAL_INTERRUPT_DISABLE_I;

  // ----------------------------------------------------------------
  // programming voltage synchroniser
  // ----------------------------------------------------------------
  logic vpp_m_r;
  logic vpp_s_r;

  // pin is asynchronous, two flops before any use
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      vpp_m_r <= 1'b0;
      vpp_s_r <= 1'b0;
    end else if (CE_I) begin
      vpp_m_r <= VPP_PRESENT_I;
      vpp_s_r <= vpp_m_r;
    end
  end

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  ltw_pkg::wstate_t state_r;
  ltw_pkg::wstate_t state_nxt;
  logic halt_r, halt_nxt;
  logic prog_r, prog_nxt;
  logic abort_r, abort_nxt;
  logic vector_r, vector_nxt;
  logic resume_r, resume_nxt;
  logic [2:0] clr_r, clr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [31:0] dur_r, dur_nxt;
  logic done_evt;
  logic long_end;

  // next state and one-cycle strobes
  always_comb begin
    state_nxt = state_r;
    halt_nxt = halt_r;
    prog_nxt = prog_r;
    abort_nxt = 1'b0;
    vector_nxt = 1'b0;
    resume_nxt = 1'b0;
    clr_nxt = 3'h0;
    cnt_nxt = cnt_r;
    dur_nxt = dur_r;
    done_evt = 1'b0;
    long_end = 1'b0;
    case (state_r)
      ltw_pkg::ST_IDLE: begin
        if (TBLWT_REQ_I) begin
          if (src.pending) begin
            // [RULE5] abort as no-op
            abort_nxt = 1'b1;
            clr_nxt = core_clr;
            done_evt = 1'b1;
          end else if (TBLWT_INTERNAL_I && vpp_s_r) begin
            // [RULE1] enter long write
            state_nxt = ltw_pkg::ST_LONG;
            halt_nxt = 1'b1;
            prog_nxt = 1'b1;
            dur_nxt = 32'h0000_0000;
          end else if (TBLWT_INTERNAL_I) begin
            // [RULE11] short write, no programming
            state_nxt = ltw_pkg::ST_SHORT;
            halt_nxt = 1'b1;
            cnt_nxt = `LTW_SHORT_CYCLES - 2'd1;
          end
        end
      end
      ltw_pkg::ST_SHORT: begin
        if (cnt_r == 2'd0) begin
          state_nxt = ltw_pkg::ST_IDLE;
          halt_nxt = 1'b0;
          resume_nxt = 1'b1;
          done_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 2'd1;
        end
      end
      ltw_pkg::ST_LONG: begin
        // [RULE2] only a qualified source ends it
        if (src.pending) begin
          state_nxt = ltw_pkg::ST_IDLE;
          halt_nxt = 1'b0;
          prog_nxt = 1'b0;
          // [RULE4] clear winning core flag
          // [RULE9] clear without branch
          clr_nxt = core_clr;
          // [RULE3] disable gates vector only
          // [RULE7] vector or resume by disable bit
          // [RULE8] core branch taken
          // [RULE10] no branch when disabled
          vector_nxt = ~gid;
          // [RULE13] resume next instruction
          resume_nxt = gid;
          done_evt = 1'b1;
          long_end = 1'b1;
        end else begin
          dur_nxt = dur_r + 32'h0000_0001;
        end
      end
      default: begin
        state_nxt = ltw_pkg::ST_IDLE;
        halt_nxt = 1'b0;
        prog_nxt = 1'b0;
      end
    endcase
  end

  // state flops; reset also ends a long write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_r <= ltw_pkg::ST_IDLE;
      halt_r <= 1'b0;
      prog_r <= 1'b0;
      abort_r <= 1'b0;
      vector_r <= 1'b0;
      resume_r <= 1'b0;
      clr_r <= 3'h0;
      cnt_r <= 2'd0;
      dur_r <= `LTW_RST_WORD;
    end else if (CE_I) begin
      state_r <= state_nxt;
      halt_r <= halt_nxt;
      prog_r <= prog_nxt;
      abort_r <= abort_nxt;
      vector_r <= vector_nxt;
      resume_r <= resume_nxt;
      clr_r <= clr_nxt;
      cnt_r <= cnt_nxt;
      dur_r <= dur_nxt;
    end
  end

  assign HALT_O = halt_r;
  assign PROG_O = prog_r;
  assign ABORT_O = abort_r;
  assign VECTOR_O = vector_r;
  assign RESUME_O = resume_r;
  assign CORE_FLAG_CLR_O = clr_r;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  logic done_r;
  logic last_vec_r;
  logic last_abort_r;
  logic last_short_r;
  logic [3:0] cause_r;
  logic [15:0] cnt_long_r;
  logic [31:0] stat_word;

  wire wb_req = CYC_I & STB_I;
  // write lands only at the edge where the master sees ack
  wire wb_wr = wb_req & WE_I & ack_r;
  wire hit_ctrl = ADR_I == `LTW_OFS_CTRL;
  wire hit_stat = ADR_I == `LTW_OFS_STAT;
  wire hit_dur = ADR_I == `LTW_OFS_DUR;
  wire hit_cnt = ADR_I == `LTW_OFS_CNT;
  wire stat_clr = wb_wr & hit_ctrl & SEL_I[0] & DAT_I[`LTW_CTRL_CLR];
  // unmapped offsets read zero and are still acknowledged
  wire [31:0] rd_mux = hit_stat ? stat_word :
                       hit_dur ? dur_r :
                       hit_cnt ? {16'h0000, cnt_long_r} :
                       32'h0000_0000;

  // status word assembly
  always_comb begin
    stat_word = `LTW_RST_WORD;
    stat_word[`LTW_ST_BUSY] = halt_r;
    stat_word[`LTW_ST_DONE] = done_r;
    stat_word[`LTW_ST_VEC] = last_vec_r;
    stat_word[`LTW_ST_ABORT] = last_abort_r;
    stat_word[`LTW_ST_SHORT] = last_short_r;
    stat_word[`LTW_ST_VPP] = vpp_s_r;
    stat_word[`LTW_ST_PROG] = prog_r;
    stat_word[`LTW_ST_CAUSE_HI:`LTW_ST_CAUSE_LO] = cause_r;
  end

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ack_r <= 1'b0;
      rdat_r <= `LTW_RST_WORD;
    end else if (CE_I) begin
      ack_r <= wb_req & ~ack_r;
      rdat_r <= (wb_req & ~ack_r & ~WE_I) ? rd_mux : `LTW_RST_WORD;
    end
  end

  // sticky done: a new event beats a clear in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      done_r <= 1'b0;
    end else if (CE_I) begin
      done_r <= done_evt | (done_r & ~stat_clr);
    end
  end

  // record of the last finished write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      last_vec_r <= 1'b0;
      last_abort_r <= 1'b0;
      last_short_r <= 1'b0;
      cause_r <= 4'h0;
      cnt_long_r <= `LTW_RST_CNT;
    end else if (CE_I && done_evt) begin
      last_vec_r <= vector_nxt;
      last_abort_r <= abort_nxt;
      last_short_r <= (state_r == ltw_pkg::ST_SHORT);
      cause_r <= long_end | abort_nxt ? src.win : 4'h0;
      cnt_long_r <= cnt_long_r + {15'h0000, long_end};
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = rdat_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_long_entry: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE1]
    (CE_I && state_r == ltw_pkg::ST_IDLE && TBLWT_REQ_I && TBLWT_INTERNAL_I && vpp_s_r
     && !src.pending) |=> (HALT_O && PROG_O && state_r == ltw_pkg::ST_LONG))
    else $error("internal write with voltage did not start long write");

  a_long_holds: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE2]
    (state_r == ltw_pkg::ST_LONG && !(CE_I && src.pending)) |=> (HALT_O && PROG_O))
    else $error("long write ended without a qualified source");

  a_long_ends: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE2]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.pending) |=> (!HALT_O && !PROG_O))
    else $error("qualified source did not end long write");

  a_gid_no_block: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE3]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.pending && gid) |=> (!HALT_O && RESUME_O))
    else $error("global disable blocked termination");

  a_core_clear: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE4]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.pending && src.win_core)
    |=> (CORE_FLAG_CLR_O == $past(src.win[2:0]) && $onehot(CORE_FLAG_CLR_O)))
    else $error("winning core flag not cleared");

  a_abort_nop: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE5]
    (CE_I && state_r == ltw_pkg::ST_IDLE && TBLWT_REQ_I && src.pending)
    |=> (ABORT_O && !HALT_O && !PROG_O && CORE_FLAG_CLR_O == $past(core_clr)))
    else $error("pending interrupt did not abort table write");

  a_periph_kept: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE6]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.pending && !src.win_core)
    |=> (CORE_FLAG_CLR_O == 3'h0 && !HALT_O))
    else $error("peripheral termination touched a core flag");

  a_vector_sel: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE7]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.pending)
    |=> (VECTOR_O == !$past(gid) && RESUME_O == $past(gid)))
    else $error("vector choice does not follow global disable");

  a_core_branch: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE8]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.win_core && !gid)
    |=> (VECTOR_O && CORE_FLAG_CLR_O != 3'h0) ##1 (!VECTOR_O && CORE_FLAG_CLR_O == 3'h0))
    else $error("core source with interrupts on did not branch once");

  a_core_quiet: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE9]
    (CE_I && state_r == ltw_pkg::ST_LONG && src.win_core && gid)
    |=> (!VECTOR_O && CORE_FLAG_CLR_O != 3'h0 && !HALT_O))
    else $error("core source with interrupts off mishandled");

  a_no_action: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE10]
    (state_r == ltw_pkg::ST_LONG && !src.pending)
    |=> (!VECTOR_O && !RESUME_O && CORE_FLAG_CLR_O == 3'h0))
    else $error("unqualified source caused an action");

  a_short_start: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE11]
    (CE_I && state_r == ltw_pkg::ST_IDLE && TBLWT_REQ_I && TBLWT_INTERNAL_I && !vpp_s_r
     && !src.pending) |=> (HALT_O && !PROG_O))
    else $error("write without voltage did not start short write");

  a_short_len: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE11]
    (CE_I && state_r == ltw_pkg::ST_IDLE && TBLWT_REQ_I && TBLWT_INTERNAL_I && !vpp_s_r
     && !src.pending) ##1 CE_I [*2] |=> (!HALT_O && RESUME_O && !PROG_O))
    else $error("short write not two cycles");

  a_resume_next: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RULE13]
    $fell(HALT_O) |-> (RESUME_O || VECTOR_O))
    else $error("halt released without resume or vector");

endmodule

// ### bench/irq_flags_model.sv
// Purpose: stand-in for the interrupt logic that owns the source flags
// Assumes: one clock, synchronous active high reset
// Notes: bench sets flags, the write controller strobes core clears
module irq_flags_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // set and clear requests
  input wire logic [3:0] set_i,
  input wire logic [2:0] core_clr_i,
  input wire logic per_clr_i,
  // flag state
  output logic [2:0] core_flag_o,
  output logic per_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  // flags latch even when disabled; a set wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_flag_o <= 3'h0;
      per_flag_o <= 1'b0;
    end else begin
      core_flag_o <= (core_flag_o & ~core_clr_i) | set_i[2:0];
      per_flag_o <= (per_flag_o & ~per_clr_i) | set_i[3];
    end
  end
endmodule

// ### bench/tb_top.sv
// Purpose: self-checking bench for the long table write controller
// Assumes: 50 MHz clock, inputs driven by non-blocking assignment at an edge or 1 ns after one
// Notes: pulses are sampled 1 ns after the edge so they are seen settled; wb samples ack and data at the edge
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, req = 0, intl = 0;
  logic gid = 0, vpp = 0, per_en = 0, per_clr = 0, ce = 1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, set = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [2:0] core_en = 3'h0, core_flag, clr_o, c;
  logic per_flag, ack, halt, prog, abort, vec, res, v, r, a, p;
  int bad_count = 0, compares = 0, cycles = 0, n;

  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  long_table_write_control dut_u (.MCLK_I(clk), .RST_I(rst), .CE_I(ce),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(dat_o), .ACK_O(ack), .TBLWT_REQ_I(req), .TBLWT_INTERNAL_I(intl),
    .HALT_O(halt), .PROG_O(prog), .ABORT_O(abort), .VECTOR_O(vec), .RESUME_O(res),
    .CORE_FLAG_I(core_flag), .CORE_EN_I(core_en), .PER_FLAG_I(per_flag),
    .PER_EN_I(per_en), .GLOBAL_INTERRUPT_DISABLE_I(gid), .CORE_FLAG_CLR_O(clr_o),
    .VPP_PRESENT_I(vpp));
  irq_flags_model irq_u (.clk_i(clk), .rst_i(rst), .set_i(set), .core_clr_i(clr_o),
    .per_clr_i(per_clr), .core_flag_o(core_flag), .per_flag_o(per_flag));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    chk("wb_ack", {31'h0, ack}, 32'h1);
  endtask
  task issue(input logic internal);
    @(posedge clk);
    req <= 1;
    intl <= internal;
    @(posedge clk);
    req <= 0;
  endtask
  task fire(input logic [3:0] s);
    @(posedge clk);
    set <= s;
    @(posedge clk);
    set <= 4'h0;
  endtask
  task pclr;
    @(posedge clk);
    per_clr <= 1;
    @(posedge clk);
    per_clr <= 0;
  endtask
  // waits for the closing pulse, remembering whether programming was seen
  task wait_end;
    n = 0;
    #1;
    p = prog;
    while (!(vec | res | abort) && n < 100) begin
      @(posedge clk);
      #1;
      p = p | prog;
      n++;
    end
    v = vec;
    r = res;
    a = abort;
    c = clr_o;
  endtask
  task hold(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      chk("halt_prog", {31'h0, halt & prog}, 32'h1);
    end
  endtask
  task ends(input logic [2:0] e, input logic [2:0] ec);
    chk("end_kind", {28'h0, v, r, a, halt}, {28'h0, e, 1'b0});
    chk("flag_clr", {29'h0, c}, {29'h0, ec});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    wb(0, 8'h04, 0);
    chk("stat_rst", rd, 32'h0);
    wb(0, 8'h0C, 0);
    chk("cnt_rst", rd, 32'h0);
    issue(1);
    wait_end;
    ends(3'b010, 3'b000);
    chk("short_len", n, 2);
    chk("short_prog", {31'h0, p}, 32'h0);
    wb(0, 8'h04, 0);
    chk("stat_short", rd, 32'h12);
    // only the timing source enabled, voltage raised
    // software programming order
    vpp <= 1;
    core_en <= 3'b010;
    issue(0);
    #1;
    chk("ext_halt", {31'h0, halt}, 32'h0);
    issue(1);
    hold(4);
    fire(4'b0010);
    wait_end;
    ends(3'b100, 3'b010);
    repeat (2) @(posedge clk);
    chk("ovf_flag", {29'h0, core_flag}, 32'h0);
    gid <= 1;
    core_en <= 3'b001;
    issue(1);
    fire(4'b0100);
    hold(4);
    fire(4'b0001);
    wait_end;
    ends(3'b010, 3'b001);
    chk("resume_next", n, 1);
    core_en <= 3'b101;
    per_en <= 1;
    fire(4'b1000);
    issue(1);
    wait_end;
    ends(3'b001, 3'b100);
    chk("abort_now", n, 0);
    issue(1);
    wait_end;
    ends(3'b001, 3'b000);
    chk("per_kept", {31'h0, per_flag}, 32'h1);
    pclr;
    core_en <= 3'b000;
    issue(1);
    hold(2);
    fire(4'b1000);
    wait_end;
    ends(3'b010, 3'b000);
    repeat (3) @(posedge clk);
    chk("per_left", {31'h0, per_flag}, 32'h1);
    wb(0, 8'h04, 0);
    chk("stat_per", rd, 32'h822);
    wb(1, 8'h00, 32'h1);
    wb(0, 8'h04, 0);
    chk("stat_clr", rd, 32'h820);
    pclr;
    gid <= 0;
    issue(1);
    fire(4'b1000);
    wait_end;
    ends(3'b100, 3'b000);
    pclr;
    wb(1, 8'h10, 32'hFFFF_FFFF);
    wb(0, 8'h10, 0);
    chk("unmapped", rd, 32'h0);
    wb(1, 8'h0C, 32'h0);
    wb(0, 8'h0C, 0);
    chk("cnt_long", rd, 32'h4);
    issue(1);
    hold(2);
    issue(1);
    hold(2);
    // frozen clock enable must keep the long write standing
    ce <= 0;
    hold(3);
    ce <= 1;
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    #1;
    chk("rst_end", {26'h0, halt, prog, vec, clr_o}, 32'h0);
    @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    wb(0, 8'h0C, 0);
    chk("cnt_after_rst", rd, 32'h0);
    report_and_stop();
  end
endmodule
